// ===== rtl/slro_receiver.sv
// serial link receive side: framing, decode, lock and output state table
// How it works
// - one 28-bit frame per pixel clock
// - first embedded bit high, last low
// - balance-invert bit set: invert payload back
// - integrity bit validates payload before acceptance
// - descramble payload before driving outputs
// - pixel clock range 5 to 43 MHz
// - lock on any data, no training
// - side outputs are input bits 21..23
// - power-up starts recovery, lock low meanwhile
// - lock high after sequence, outputs valid
// - clock source switch holds output level
// - lost embedded clock drops lock
// - output enable low tri-states lvds outputs
// - power-down, select low: all tri-stated
// - power-down, select high: lock, side low
// - unlocked, oen low, select low row
// - unlocked, oen low, select high row
// - unlocked, oen high, select low row
// - unlocked, oen high, select high row
// - locked with oen high drives everything
// - power-down clears config, sleep keeps it
`timescale 1ns/100ps
module slro_receiver (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        link_clk,
  input  wire logic        link_data,
  input  wire logic        power_down_bar,
  input  wire logic        output_enable_pin,
  input  wire logic        inactive_state_select,
  input  wire logic        free_clock_select,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             lock_out,
  output logic             lock_oe,
  output logic             lvds_clock_out,
  output logic             lvds_clock_oe,
  output logic      [2:0]  lvds_data_lanes,
  output logic      [2:0]  lvds_data_oe,
  output logic      [2:0]  side_band_bits_out,
  output logic      [2:0]  side_band_oe,
  output logic             selftest_pass,
  output logic             selftest_pass_oe
);
  localparam int LAST = slro_pkg::FRAME_BITS - 1;
  localparam int LOCK_M1 = slro_pkg::LOCK_FRAMES - 1;

  function automatic logic parity_ok(input slro_pkg::slro_frame_s f);
    parity_ok = ((^f.payload) == f.dca);
  endfunction

  function automatic logic [slro_pkg::PAY_BITS-1:0] decode(input slro_pkg::slro_frame_s f);
    logic [slro_pkg::PAY_BITS-1:0] w;
    w = f.dcb ? ~f.payload : f.payload;
    decode = w ^ slro_pkg::SCRAMBLE_KEY;
  endfunction

  // two-stage synchronisers for every pin input
  logic [5:0] sync1;
  logic [5:0] sync2;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end else begin
      sync1 <= {free_clock_select, inactive_state_select, output_enable_pin,
                power_down_bar, link_data, link_clk};
      sync2 <= sync1;
    end
  end

  logic lclk_s;
  logic ldat_s;
  logic pd_n_s;
  logic oen_s;
  logic oss_s;
  logic free_s;
  assign {free_s, oss_s, oen_s, pd_n_s, ldat_s, lclk_s} = sync2;

  logic lclk_d;
  logic link_edge;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lclk_d <= 1'b0;
    end else begin
      lclk_d <= lclk_s;
    end
  end
  assign link_edge = lclk_s & ~lclk_d;

  // bit framing
  logic [LAST:0]              sr;
  logic [LAST:0]              next_sr;
  logic [4:0]                 bit_cnt;
  slro_pkg::slro_frame_s      frame;
  logic                       frame_done;
  logic                       clocks_ok;
  logic                       accept;
  assign next_sr    = {sr[LAST-1:0], ldat_s};
  assign frame      = slro_pkg::slro_frame_s'(next_sr);
  assign frame_done = link_edge && (bit_cnt == 5'(LAST));
  assign clocks_ok  = frame.c1 && !frame.c0;
  assign accept     = frame_done && clocks_ok && parity_ok(frame);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sr <= '0;
    end else if (link_edge) begin
      sr <= next_sr;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt <= 5'h00;
    end else if (!pd_n_s) begin
      bit_cnt <= 5'h00;
    end else if (link_edge) begin
      // slip one bit on bad framing
      if (frame_done && !clocks_ok) begin
        bit_cnt <= bit_cnt;
      end else if (bit_cnt == 5'(LAST)) begin
        bit_cnt <= 5'h00;
      end else begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // stream activity watchdog
  logic [7:0] idle_cnt;
  logic       stalled;
  assign stalled = (idle_cnt == 8'(slro_pkg::STALL_CYC));
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt <= 8'h00;
    end else if (link_edge || !pd_n_s) begin
      idle_cnt <= 8'h00;
    end else if (!stalled) begin
      idle_cnt <= idle_cnt + 8'h01;
    end
  end

  // lock sequence
  logic       lock;
  logic [2:0] good_cnt;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lock     <= 1'b0;
      good_cnt <= 3'h0;
    end else if (!pd_n_s || stalled) begin
      lock     <= 1'b0;
      good_cnt <= 3'h0;
    end else if (frame_done) begin
      if (!clocks_ok) begin
        lock     <= 1'b0;
        good_cnt <= 3'h0;
      end else if (good_cnt == 3'(LOCK_M1)) begin
        lock <= 1'b1;
      end else begin
        good_cnt <= good_cnt + 3'h1;
      end
    end
  end

  // payload decode
  logic [slro_pkg::PAY_BITS-1:0]  pix_word;
  logic [slro_pkg::SIDE_BITS-1:0] side_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pix_word <= '0;
    end else if (accept) begin
      pix_word <= decode(frame);
    end
  end

  logic [slro_pkg::PAY_BITS-1:0] acc_word;
  assign acc_word = decode(frame);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      side_q <= '0;
    end else if (accept && lock) begin
      side_q <= acc_word[slro_pkg::SIDE_LSB +: slro_pkg::SIDE_BITS];
    end
  end

  // lane serialisation and recovered clock level
  logic [2:0] lane_q;
  logic       rec_lvl;
  logic [2:0] lane_idx;
  assign lane_idx = 3'(bit_cnt / 5'(slro_pkg::LINK_PER_LANE));
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lane_q  <= 3'h0;
      rec_lvl <= 1'b0;
    end else if (link_edge) begin
      rec_lvl <= (bit_cnt < 5'(slro_pkg::REC_HIGH_BITS));
      for (int k = 0; k < slro_pkg::LANES; k++) begin
        lane_q[k] <= pix_word[k * slro_pkg::LANE_BITS + int'(lane_idx)];
      end
    end
  end

  // free-running clock divider
  logic [3:0] free_cnt;
  logic       free_lvl;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      free_cnt <= 4'h0;
      free_lvl <= 1'b0;
    end else if (free_cnt == 4'(slro_pkg::FREE_HALF_CYC - 1)) begin
      free_cnt <= 4'h0;
      free_lvl <= ~free_lvl;
    end else begin
      free_cnt <= free_cnt + 4'h1;
    end
  end

  // registers: power-down clears, stream sleep keeps
  logic [slro_pkg::CTRL_W-1:0] ctrl;
  logic [15:0]                 err_cnt;
  logic                        bus_ack;
  logic                        bus_req;
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~bus_ack;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= slro_pkg::CTRL_RST;
    end else if (!pd_n_s) begin
      ctrl <= slro_pkg::CTRL_RST;
    end else if (avs_write && bus_ack && avs_address == slro_pkg::REG_CTRL) begin
      ctrl <= avs_writedata[slro_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      err_cnt <= 16'h0000;
    end else if (!pd_n_s) begin
      err_cnt <= 16'h0000;
    end else if (frame_done && clocks_ok && !parity_ok(frame)) begin
      err_cnt <= err_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !bus_ack) begin
      unique case (avs_address)
        slro_pkg::REG_CTRL:   avs_readdata <= {29'h0, ctrl};
        slro_pkg::REG_STATUS: avs_readdata <= {29'h0, ~pd_n_s, ~stalled, lock};
        slro_pkg::REG_ERRCNT: avs_readdata <= {16'h0000, err_cnt};
        default:              avs_readdata <= 32'h00000000;
      endcase
    end
  end

  logic oss_eff;
  logic free_eff;
  assign oss_eff  = ctrl[slro_pkg::CTRL_OSS_EN] ? ctrl[slro_pkg::CTRL_OSS_VAL] : oss_s;
  assign free_eff = free_s | ctrl[slro_pkg::CTRL_FREE_SEL];

  // glitch-free output clock source
  slro_pkg::slro_src_e clk_src;
  slro_pkg::slro_src_e target;
  logic                clk_q;

  function automatic logic src_lvl(input slro_pkg::slro_src_e s, input logic rl,
                                   input logic fl, input logic hold);
    unique case (s)
      slro_pkg::SRC_REC:  src_lvl = rl;
      slro_pkg::SRC_FREE: src_lvl = fl;
      slro_pkg::SRC_NONE: src_lvl = hold;
      default:            src_lvl = hold;
    endcase
  endfunction

  assign target = lock ? slro_pkg::SRC_REC : (free_eff ? slro_pkg::SRC_FREE : slro_pkg::SRC_NONE);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      clk_src <= slro_pkg::SRC_NONE;
    end else if (clk_src != target
                 && src_lvl(target, rec_lvl, free_lvl, clk_q) == clk_q) begin
      clk_src <= target;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      clk_q <= 1'b0;
    end else if (clk_src == target) begin
      clk_q <= src_lvl(clk_src, rec_lvl, free_lvl, clk_q);
    end else begin
      clk_q <= clk_q;
    end
  end

  // output state table
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lock_out           <= 1'b0;
      lock_oe            <= 1'b0;
      lvds_clock_out     <= 1'b0;
      lvds_clock_oe      <= 1'b0;
      lvds_data_lanes    <= 3'h0;
      lvds_data_oe       <= 3'h0;
      side_band_bits_out <= 3'h0;
      side_band_oe       <= 3'h0;
      selftest_pass      <= 1'b0;
      selftest_pass_oe   <= 1'b0;
    end else begin
      lock_out           <= 1'b0;
      lock_oe            <= 1'b1;
      lvds_clock_out     <= 1'b0;
      lvds_clock_oe      <= 1'b0;
      lvds_data_lanes    <= 3'h0;
      lvds_data_oe       <= 3'h0;
      side_band_bits_out <= 3'h0;
      side_band_oe       <= 3'h7;
      selftest_pass      <= ~oss_eff;
      selftest_pass_oe   <= 1'b1;
      if (!pd_n_s) begin
        selftest_pass_oe <= 1'b0;
        selftest_pass    <= 1'b0;
        if (!oss_eff) begin
          lock_oe      <= 1'b0;
          side_band_oe <= 3'h0;
        end
        // lock and side bits low otherwise
      end else if (lock) begin
        lock_out           <= 1'b1;
        side_band_bits_out <= side_q;
        selftest_pass      <= 1'b1;
        if (oen_s) begin
          lvds_clock_out  <= clk_q;
          lvds_clock_oe   <= 1'b1;
          lvds_data_lanes <= lane_q;
          lvds_data_oe    <= 3'h7;
        end
      end else if (oen_s && !oss_eff) begin
        side_band_oe <= 3'h0;
      end else if (oen_s) begin
        lvds_data_oe <= 3'h7;
      end
      // unlocked with oen low: defaults above
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_LOCK_AFTER_FRAMES: assert property ($rose(lock) |-> $past(good_cnt) == 3'(LOCK_M1))
    else $error("lock rose without enough good frames");
  AST_PD_NO_LOCK: assert property (!pd_n_s |=> !lock)
    else $error("lock high during power-down");
  AST_STALL_DROP: assert property (stalled && pd_n_s |=> !lock ##1 !lock_out)
    else $error("lock kept after stream stopped");
  AST_OEN_LOW: assert property (pd_n_s && !oen_s |=> !lvds_clock_oe && lvds_data_oe == 3'h0)
    else $error("lvds driven with output enable low");
  AST_PD_SEL_LOW: assert property (!pd_n_s && !oss_eff |=>
      !lock_oe && side_band_oe == 3'h0 && !selftest_pass_oe && !lvds_clock_oe)
    else $error("pin driven in power-down with select low");
  AST_PD_SEL_HIGH: assert property (!pd_n_s && oss_eff |=>
      lock_oe && !lock_out && side_band_oe == 3'h7 && side_band_bits_out == 3'h0)
    else $error("power-down select high row wrong");
  AST_UNL_OEN_HIGH_SEL_HIGH: assert property (pd_n_s && !lock && oen_s && oss_eff |=>
      lvds_data_oe == 3'h7 && lvds_data_lanes == 3'h0 && !lvds_clock_oe && !selftest_pass)
    else $error("unlocked oen high select high row wrong");
  AST_UNL_OEN_HIGH_SEL_LOW: assert property (pd_n_s && !lock && oen_s && !oss_eff |=>
      side_band_oe == 3'h0 && selftest_pass && lvds_data_oe == 3'h0)
    else $error("unlocked oen high select low row wrong");
  AST_UNL_OEN_LOW: assert property (pd_n_s && !lock && !oen_s |=>
      side_band_oe == 3'h7 && selftest_pass == ~$past(oss_eff))
    else $error("unlocked oen low row wrong");
  AST_INVERT_DECODE: assert property (accept |=>
      pix_word == (($past(frame.dcb) ? ~$past(frame.payload) : $past(frame.payload))
                   ^ slro_pkg::SCRAMBLE_KEY))
    else $error("payload not un-inverted and descrambled");
  AST_PARITY_REJECT: assert property (frame_done && !parity_ok(frame) |=> $stable(pix_word))
    else $error("payload accepted with bad integrity bit");
  AST_SIDE_FROZEN: assert property (!lock |=> $stable(side_q))
    else $error("side bits changed while unlocked");
  AST_SIDE_MAP: assert property (accept && lock |=> side_q == $past(acc_word[23:21]))
    else $error("side bits not taken from bits 21 to 23");
  AST_SWITCH_HOLD: assert property (clk_src != target |=> clk_q == $past(clk_q))
    else $error("output clock moved during source switch");

  COV_LOCK: cover property ($rose(lock));
  COV_PARITY_BAD: cover property (frame_done && clocks_ok && !parity_ok(frame));
  COV_SWITCH: cover property (clk_src == slro_pkg::SRC_FREE ##[1:300] clk_src == slro_pkg::SRC_REC);
  COV_STALL: cover property (lock ##1 stalled);
endmodule

// ===== rtl/slro_pkg.sv
// shared constants and types of the serial link receive output-state block
package slro_pkg;
  localparam int FRAME_BITS    = 28;
  localparam int PAY_BITS      = 24;
  localparam int LANES         = 3;
  localparam int LANE_BITS     = 7;
  localparam int SIDE_BITS     = 3;
  localparam int SIDE_LSB      = 21;
  localparam int LINK_PER_LANE = 4;
  localparam int REC_HIGH_BITS = 14;
  localparam int LOCK_FRAMES   = 4;

  localparam int CLK_SYS_MHZ   = 20;
  localparam int STALL_NS      = 2000;
  localparam int STALL_CYC     = (STALL_NS * CLK_SYS_MHZ) / 1000;
  localparam int FREE_HALF_NS  = 200;
  localparam int FREE_HALF_CYC = (FREE_HALF_NS * CLK_SYS_MHZ) / 1000;

  localparam logic [PAY_BITS-1:0] SCRAMBLE_KEY = 24'h5ac396;

  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ERRCNT = 4'h8;

  localparam int CTRL_OSS_EN   = 0;
  localparam int CTRL_OSS_VAL  = 1;
  localparam int CTRL_FREE_SEL = 2;
  localparam int CTRL_W        = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

  localparam int ST_LOCK   = 0;
  localparam int ST_ACTIVE = 1;
  localparam int ST_PD     = 2;

  // received order: embedded_clock_high_bit first, embedded_clock_low_bit last
  typedef struct packed {
    logic                c1;
    logic [PAY_BITS-1:0] payload;
    logic                dcb;
    logic                dca;
    logic                c0;
  } slro_frame_s;

  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_FREE = 2'b01,
    SRC_REC  = 2'b10
  } slro_src_e;
endpackage

// ===== bench/slro_serializer.sv
// remote serializer model driving the serial link
`timescale 1ns/100ps
module slro_serializer (
  input  wire logic        run,
  input  wire logic [23:0] word,
  input  wire logic        inv,
  input  wire logic        bad_par,
  output logic             link_clk,
  output logic             link_data,
  output logic      [15:0] frames_sent
);
  logic                  bit_clk = 1'b0;
  logic                  active  = 1'b0;
  logic [4:0]            idx     = 5'h0;
  logic [23:0]           pay;
  slro_pkg::slro_frame_s frame;

  // 400 ns bit clock, phase unrelated to the system clock
  initial begin
    #37;
    forever #200 bit_clk = ~bit_clk;
  end

  // clock stops only between frames, once run is low; gated only while low
  assign link_clk = bit_clk & active;

  // data changes on the falling edge, taken on the rising one
  initial begin
    link_data   = 1'b0;
    frames_sent = 16'h0;
    forever @(negedge bit_clk) begin
    if (idx == 5'h0) begin
      active = run;
      pay = (word ^ slro_pkg::SCRAMBLE_KEY) ^ {24{inv}};
      frame.c1      = 1'b1;
      frame.c0      = 1'b0;
      frame.payload = pay;
      frame.dcb     = inv;
      frame.dca     = (^pay) ^ bad_par;
    end
    if (!active) begin
      link_data = ~link_data;
    end else begin
      // one 28-bit frame per pixel period
      link_data = frame[5'd27 - idx];
      if (idx == 5'd27) begin
        idx         = 5'h0;
        frames_sent = frames_sent + 16'h1;
      end else begin
        idx = idx + 5'h1;
      end
    end
  end
  end
endmodule

// ===== bench/tb.sv
// self-checking testbench of the serial link receive output-state block
`timescale 1ns/100ps
module tb;
  logic        clk_sys               = 1'b0;
  logic        rst_b                 = 1'b0;
  logic        power_down_bar        = 1'b0;
  logic        output_enable_pin     = 1'b0;
  logic        inactive_state_select = 1'b0;
  logic        free_clock_select     = 1'b0;
  logic [3:0]  avs_address           = 4'h0;
  logic        avs_read              = 1'b0;
  logic        avs_write             = 1'b0;
  logic [31:0] avs_writedata         = 32'h0;
  logic        run                   = 1'b0;
  logic [23:0] word                  = 24'h0;
  logic        inv                   = 1'b0;
  logic        bad_par               = 1'b0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        lock_out, lock_oe, lvds_clock_out, lvds_clock_oe;
  logic [2:0]  lvds_data_lanes, lvds_data_oe, side_band_bits_out, side_band_oe;
  logic        selftest_pass, selftest_pass_oe;
  logic        link_clk, link_data;
  logic [15:0] frames_sent;
  logic [16:0] out_vec;
  int          err_count    = 0;
  int          total_checks = 0;

  always #25 clk_sys = ~clk_sys;

  assign out_vec = {lock_oe, lock_out, lvds_clock_oe, lvds_data_oe, lvds_data_lanes,
                    side_band_oe, side_band_bits_out, selftest_pass_oe, selftest_pass};

  slro_serializer u_slro_serializer (
    .run(run), .word(word), .inv(inv), .bad_par(bad_par),
    .link_clk(link_clk), .link_data(link_data), .frames_sent(frames_sent));

  slro_receiver u_slro_receiver (
    .clk_sys(clk_sys), .rst_b(rst_b), .link_clk(link_clk), .link_data(link_data),
    .power_down_bar(power_down_bar), .output_enable_pin(output_enable_pin),
    .inactive_state_select(inactive_state_select), .free_clock_select(free_clock_select),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lock_out(lock_out), .lock_oe(lock_oe),
    .lvds_clock_out(lvds_clock_out), .lvds_clock_oe(lvds_clock_oe),
    .lvds_data_lanes(lvds_data_lanes), .lvds_data_oe(lvds_data_oe),
    .side_band_bits_out(side_band_bits_out), .side_band_oe(side_band_oe),
    .selftest_pass(selftest_pass), .selftest_pass_oe(selftest_pass_oe));

  task give_verdict;
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // holds the request until waitrequest is seen low at a rising edge
  task av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
               output logic [31:0] q);
    logic w;
    int   n;
    n = 0;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge clk_sys);
    w = avs_waitrequest;
    while (w !== 1'b0 && n < 50) begin
      @(posedge clk_sys);
      w = avs_waitrequest;
      n++;
    end
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    check({31'h0, w}, 32'h0);
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    av_xfer(1'b1, a, d, q);
  endtask

  task rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    av_xfer(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  // pins pass two sync stages and one output register
  task pins(input logic p, input logic o, input logic s);
    @(posedge clk_sys);
    power_down_bar        <= p;
    output_enable_pin     <= o;
    inactive_state_select <= s;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task wait_frames(input int n);
    logic [15:0] f0;
    f0 = frames_sent;
    repeat (300 * n) begin
      @(posedge clk_sys);
      if (frames_sent == f0 + n[15:0]) break;
    end
  endtask

  task test_table;
    logic [16:0] exp_row [8];
    exp_row = '{17'h0, 17'h100e0, 17'h0, 17'h100e0,
                17'h100e3, 17'h100e2, 17'h10003, 17'h138e2};
    for (int i = 0; i < 8; i++) begin
      pins(i[2], i[1], i[0]);
      check({15'h0, out_vec}, {15'h0, exp_row[i]});
    end
  endtask

  task test_regs;
    pins(1'b1, 1'b1, 1'b0);
    rd_chk(4'hc, 32'h0);
    wr(4'hc, 32'hffffffff);
    rd_chk(4'hc, 32'h0);
    wr(slro_pkg::REG_STATUS, 32'hffffffff);
    // no link edges for long enough to count as stalled
    repeat (slro_pkg::STALL_CYC) @(posedge clk_sys);
    rd_chk(slro_pkg::REG_STATUS, 32'h0);
    // override selects the high inactive state while the pin is low
    wr(slro_pkg::REG_CTRL, 32'hfffffffb);
    rd_chk(slro_pkg::REG_CTRL, 32'h3);
    @(negedge clk_sys);
    check({15'h0, out_vec}, 32'h138e2);
    pins(1'b0, 1'b1, 1'b0);
    check({15'h0, out_vec}, 32'h0);
    rd_chk(slro_pkg::REG_STATUS, 32'h6);
    rd_chk(slro_pkg::REG_CTRL, 32'h0);
    wr(slro_pkg::REG_CTRL, 32'h3);
    rd_chk(slro_pkg::REG_CTRL, 32'h0);
    pins(1'b1, 1'b1, 1'b0);
  endtask

  task test_lock;
    int         n;
    logic [1:0] seen;
    n    = 0;
    seen = 2'b00;
    @(posedge clk_sys);
    word <= 24'hbfffff;
    run  <= 1'b1;
    // free clock taken up shortly before lock so the handover follows soon
    repeat (800) @(posedge clk_sys);
    free_clock_select <= 1'b1;
    while (lock_out !== 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    check({31'h0, lock_out}, 32'h1);
    wait_frames(2);
    @(negedge clk_sys);
    check({15'h0, out_vec}, 32'h1fff7);
    repeat (448) begin
      @(negedge clk_sys);
      if (lvds_clock_out === 1'b1) seen[1] = 1'b1;
      if (lvds_clock_out === 1'b0) seen[0] = 1'b1;
    end
    check({30'h0, seen}, 32'h3);
    rd_chk(slro_pkg::REG_STATUS, 32'h3);
    pins(1'b1, 1'b0, 1'b0);
    check({15'h0, out_vec}, 32'h180f7);
    pins(1'b1, 1'b1, 1'b0);
  endtask

  // side bits held for many frames, as a slow level
  task test_codes;
    @(posedge clk_sys);
    word <= 24'h400000;
    inv  <= 1'b1;
    wait_frames(3);
    @(negedge clk_sys);
    check({26'h0, side_band_bits_out, lvds_data_lanes}, 32'h10);
    wait_frames(1);
    word    <= 24'hffffff;
    bad_par <= 1'b1;
    wait_frames(1);
    word    <= 24'h400000;
    bad_par <= 1'b0;
    wait_frames(2);
    @(negedge clk_sys);
    check({26'h0, side_band_bits_out, lvds_data_lanes}, 32'h10);
    rd_chk(slro_pkg::REG_ERRCNT, 32'h1);
  endtask

  task test_stop;
    wr(slro_pkg::REG_CTRL, 32'h1);
    @(posedge clk_sys);
    run <= 1'b0;
    wait_frames(1);
    repeat (60) @(posedge clk_sys);
    @(negedge clk_sys);
    check({15'h0, out_vec}, 32'h10003);
    rd_chk(slro_pkg::REG_STATUS, 32'h0);
    rd_chk(slro_pkg::REG_CTRL, 32'h1);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    test_table();
    test_regs();
    test_lock();
    test_codes();
    test_stop();
    give_verdict();
  end

  initial begin
    repeat (90000) @(posedge clk_sys);
    err_count++;
    give_verdict();
  end
endmodule
